// *** logic/miet_core.sv ***
// Purpose: 8-bit core sequencing instructions in four-clock cycles
// Assumes: Program memory answers before the second clock edge after the address is shown
// Notes: One instruction at a time, no overlap of fetch and execute

`timescale 1ns/1ns
`default_nettype none

module miet_core
	import miet_pkg::*;
#(
	parameter int unsigned STK_DEPTH = STACK_DEPTH,
	parameter int unsigned DM_WORDS = DM_DEPTH
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [15:0] prog_data_in,
	input wire logic wake_in,
	output logic [11:0] prog_addr_out,
	output logic [7:0] acc_out,
	output logic [3:0] flags_out,
	output logic [7:0] table_high_out,
	output logic cycle_start_out,
	output logic power_down_out
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	miet_state_t state_q;
	logic [1:0] phase_q;
	logic [11:0] pc_q, pc_d, prog_addr_q, stack_top, table_addr;
	logic [15:0] ir_q;
	logic [7:0] acc_q, table_high_q, imm, ram_rd, opnd, op_b, res;
	logic [3:0] op, sub;
	logic [6:0] m_addr;
	logic [8:0] sum;
	logic [4:0] nib;
	logic z_q, c_q, ac_q, ov_q, c_n, ac_n, ov_n;
	logic tbl_pending_q, cycle_start_q, power_down_q, exec_now;
	logic cin, wr_acc, wr_mem, wr_pcl, ram_we, upd_z, upd_c, upd_arith;
	logic skip, push, pop, extra, go_down;

	// One-hot mask of the selected bit, shared by bit set, clear and test
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	////////////////////////////////////////////////////////////////////////
	// Instruction fields

	assign op = ir_q[15:12];
	assign sub = ir_q[11:8];
	assign imm = ir_q[7:0];
	assign m_addr = ir_q[6:0];
	assign exec_now = (state_q == MIET_RUN) && (phase_q == PH_EXEC);
	// Program low byte reads as the address of the current instruction
	assign opnd = (m_addr == PCL_ADDR) ? pc_q[7:0] : ram_rd;
	assign op_b = (op == OP_ALU_IMM) ? imm : opnd;
	assign table_addr = {ir_q[11:8], opnd};

	////////////////////////////////////////////////////////////////////////
	// Phase counter, four clocks per instruction cycle, and the cycle start mark

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			phase_q <= PH_FETCH;
			cycle_start_q <= 1'b0;
		end else begin
			phase_q <= phase_q + 2'h1;
			cycle_start_q <= (phase_q == PH_EXEC);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data path: result, destination and flag effects

	always_comb begin
		res = 8'h00;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_arith = 1'b0;
		c_n = c_q;
		ac_n = ac_q;
		ov_n = ov_q;
		skip = 1'b0;
		sum = 9'h000;
		nib = 5'h00;
		cin = 1'b0;
		case (op)
			OP_MOV_IMM: begin
				res = imm;
				wr_acc = 1'b1;
			end
			OP_MOV_LD: begin
				res = opnd;
				wr_acc = 1'b1;
			end
			OP_MOV_ST: begin
				res = acc_q;
				wr_mem = 1'b1;
			end
			OP_ALU_IMM, OP_ALU_ACC, OP_ALU_MEM: begin
				wr_acc = (op != OP_ALU_MEM);
				wr_mem = (op == OP_ALU_MEM);
				upd_z = 1'b1;
				case (ir_q[10:8])
					ALU_ADD, ALU_ADC: begin
						cin = (ir_q[10:8] == ALU_ADC) && c_q;
						sum = {1'b0, acc_q} + {1'b0, op_b} + {8'h00, cin};
						nib = {1'b0, acc_q[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
						res = sum[7:0];
						c_n = sum[8];
						ac_n = nib[4];
						ov_n = (acc_q[7] == op_b[7]) && (sum[7] != acc_q[7]);
						upd_c = 1'b1;
						upd_arith = 1'b1;
					end
					ALU_SUB, ALU_SBC: begin
						cin = (ir_q[10:8] == ALU_SBC) && c_q;
						sum = {1'b0, acc_q} - {1'b0, op_b} - {8'h00, cin};
						nib = {1'b0, acc_q[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
						res = sum[7:0];
						c_n = sum[8];
						ac_n = nib[4];
						ov_n = (acc_q[7] != op_b[7]) && (sum[7] != acc_q[7]);
						upd_c = 1'b1;
						upd_arith = 1'b1;
					end
					ALU_AND: res = acc_q & op_b;
					ALU_OR: res = acc_q | op_b;
					ALU_XOR: res = acc_q ^ op_b;
					default: begin
						res = acc_q;
						wr_acc = 1'b0;
						wr_mem = 1'b0;
						upd_z = 1'b0;
					end
				endcase
			end
			OP_UN_ACC, OP_UN_MEM: begin
				wr_acc = (op == OP_UN_ACC);
				wr_mem = (op == OP_UN_MEM);
				case (ir_q[10:8])
					UN_ADD_ONE: begin
						res = opnd + 8'h01;
						upd_z = 1'b1;
					end
					UN_MINUS_ONE: begin
						res = opnd - 8'h01;
						upd_z = 1'b1;
					end
					UN_INVERT: begin
						res = ~opnd;
						upd_z = 1'b1;
					end
					UN_ROT_RIGHT: res = {opnd[0], opnd[7:1]};
					UN_ROT_LEFT: res = {opnd[6:0], opnd[7]};
					UN_ROT_RIGHT_C: begin
						res = {c_q, opnd[7:1]};
						c_n = opnd[0];
						upd_c = 1'b1;
					end
					UN_ROT_LEFT_C: begin
						res = {opnd[6:0], c_q};
						c_n = opnd[7];
						upd_c = 1'b1;
					end
					default: begin
						wr_acc = 1'b0;
						wr_mem = 1'b0;
					end
				endcase
			end
			OP_BIT_HIGH: begin
				res = opnd | bit_mask(ir_q[10:8]);
				wr_mem = 1'b1;
			end
			OP_BIT_LOW: begin
				res = opnd & ~bit_mask(ir_q[10:8]);
				wr_mem = 1'b1;
			end
			OP_SKIP_ZERO: skip = (opnd == 8'h00);
			OP_SKIP_BIT: skip = ((opnd & bit_mask(ir_q[10:8])) != 8'h00) == ir_q[11];
			default: res = 8'h00;
		endcase
	end

	// Destination of a memory write may be the program low byte
	assign wr_pcl = wr_mem && (m_addr == PCL_ADDR);
	assign ram_we = exec_now && wr_mem && !wr_pcl;

	////////////////////////////////////////////////////////////////////////
	// Control transfer: next address, stack and cycle count

	always_comb begin
		pc_d = pc_q + 12'h001;
		push = 1'b0;
		pop = 1'b0;
		extra = 1'b0;
		go_down = 1'b0;
		case (op)
			OP_BRANCH: begin
				pc_d = ir_q[11:0];
				extra = 1'b1;
			end
			OP_CALL: begin
				pc_d = ir_q[11:0];
				push = 1'b1;
				extra = 1'b1;
			end
			OP_TABLE: extra = 1'b1;
			OP_MISC: begin
				if (sub == SUB_BACK || sub == SUB_INT_EXIT) begin
					pc_d = stack_top;
					pop = 1'b1;
					extra = 1'b1;
				end else if (sub == SUB_POWER_DOWN) go_down = 1'b1;
			end
			default: begin
				if (wr_pcl) begin
					pc_d = {pc_q[11:8], res};
					extra = 1'b1;
				end else if (skip) begin
					pc_d = pc_q + 12'h002;
					extra = 1'b1;
				end
			end
		endcase
	end

	// Return stack holds the address after each call
	miet_ret_stack #(
		.DEPTH(STK_DEPTH),
		.W(PC_W)
	) u_stack (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.push_in(exec_now && push),
		.pop_in(exec_now && pop),
		.push_data_in(pc_q + 12'h001),
		.top_out(stack_top)
	);

	// Data memory, read in phase two, written at the end of phase three
	miet_data_ram #(
		.DEPTH(DM_WORDS),
		.AW(DM_AW)
	) u_ram (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.addr_in(m_addr),
		.wr_en_in(ram_we),
		.wr_data_in(res),
		.rd_data_out(ram_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer state

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= MIET_RUN;
		end else if (phase_q == PH_EXEC) begin
			case (state_q)
				MIET_RUN: begin
					if (go_down) begin
						state_q <= MIET_DOWN;
					end else if (extra) begin
						state_q <= MIET_EXTRA;
					end
				end
				MIET_EXTRA: state_q <= MIET_RUN;
				MIET_DOWN: if (wake_in) state_q <= MIET_RUN;
				default: state_q <= MIET_RUN;
			endcase
		end
	end

	// Power-down mark, registered alongside the state that it reports
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) power_down_q <= 1'b0;
		else if (phase_q == PH_EXEC) power_down_q <= (state_q == MIET_RUN) ? go_down : (power_down_q && !wake_in);
	end

	// Program counter and fetch address
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			pc_q <= RST_PC;
			prog_addr_q <= RST_PC;
		end else if (exec_now) begin
			pc_q <= pc_d;
			prog_addr_q <= (op == OP_TABLE) ? table_addr : pc_d;
		end else if (state_q == MIET_EXTRA && phase_q == PH_EXEC) prog_addr_q <= pc_q;
	end

	// Instruction register loads while the program word is valid
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) ir_q <= RST_IR;
		else if (state_q == MIET_RUN && phase_q == PH_DECODE) ir_q <= prog_data_in;
	end

	// Table read fetches the stored word during its second cycle
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tbl_pending_q <= 1'b0;
			table_high_q <= 8'h00;
		end else if (exec_now) tbl_pending_q <= (op == OP_TABLE);
		else if (tbl_pending_q && phase_q == PH_DECODE) begin
			table_high_q <= prog_data_in[15:8];
			tbl_pending_q <= 1'b0;
		end
	end

	// Accumulator
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) acc_q <= RST_ACC;
		else if (tbl_pending_q && phase_q == PH_DECODE) acc_q <= prog_data_in[7:0];
		else if (exec_now && wr_acc) acc_q <= res;
	end

	// Status flags
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			z_q <= 1'b0;
			c_q <= 1'b0;
			ac_q <= 1'b0;
			ov_q <= 1'b0;
		end else if (exec_now) begin
			if (upd_z) z_q <= (res == 8'h00);
			if (upd_c) c_q <= c_n;
			if (upd_arith) begin
				ac_q <= ac_n;
				ov_q <= ov_n;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops

	assign prog_addr_out = prog_addr_q;
	assign acc_out = acc_q;
	assign flags_out = {ov_q, ac_q, c_q, z_q};
	assign table_high_out = table_high_q;
	assign cycle_start_out = cycle_start_q;
	assign power_down_out = power_down_q;

endmodule : miet_core

`default_nettype wire

// *** logic/miet_pkg.sv ***
// Purpose: Shared constants and types of the instruction sequencing core
// Assumes: 16-bit program words, 12-bit program addresses, 8-bit data
// Notes: Opcode encoding is local to this core; see the field layout below

package miet_pkg;

	// Instruction cycle and its phases
	localparam int unsigned CLK_PER_ICYCLE = 4;
	localparam logic [1:0] PH_FETCH = 2'h0;
	localparam logic [1:0] PH_DECODE = 2'h1;
	localparam logic [1:0] PH_READ = 2'h2;
	localparam logic [1:0] PH_EXEC = 2'h3;

	// Widths and depths
	localparam int unsigned PC_W = 12;
	localparam int unsigned INSTR_W = 16;
	localparam int unsigned DM_DEPTH = 128;
	localparam int unsigned DM_AW = 7;
	localparam int unsigned STACK_DEPTH = 6;

	// Reset values and fixed locations
	localparam logic [11:0] RST_PC = 12'h000;
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [15:0] RST_IR = 16'h0000;
	localparam logic [6:0] PCL_ADDR = 7'h06;

	// Major opcodes, word bits 15..12
	localparam logic [3:0] OP_MISC = 4'h0;
	localparam logic [3:0] OP_BRANCH = 4'h1;
	localparam logic [3:0] OP_CALL = 4'h2;
	localparam logic [3:0] OP_MOV_IMM = 4'h3;
	localparam logic [3:0] OP_ALU_IMM = 4'h4;
	localparam logic [3:0] OP_ALU_ACC = 4'h5;
	localparam logic [3:0] OP_ALU_MEM = 4'h6;
	localparam logic [3:0] OP_UN_ACC = 4'h7;
	localparam logic [3:0] OP_UN_MEM = 4'h8;
	localparam logic [3:0] OP_MOV_LD = 4'h9;
	localparam logic [3:0] OP_MOV_ST = 4'hA;
	localparam logic [3:0] OP_BIT_HIGH = 4'hB;
	localparam logic [3:0] OP_BIT_LOW = 4'hC;
	localparam logic [3:0] OP_SKIP_ZERO = 4'hD;
	localparam logic [3:0] OP_SKIP_BIT = 4'hE;
	localparam logic [3:0] OP_TABLE = 4'hF;

	// Misc sub-codes, word bits 11..8
	localparam logic [3:0] SUB_NOP = 4'h0;
	localparam logic [3:0] SUB_POWER_DOWN = 4'h1;
	localparam logic [3:0] SUB_BACK = 4'h2;
	localparam logic [3:0] SUB_INT_EXIT = 4'h3;

	// Two-operand operations, word bits 10..8
	localparam logic [2:0] ALU_ADD = 3'h0;
	localparam logic [2:0] ALU_ADC = 3'h1;
	localparam logic [2:0] ALU_SUB = 3'h2;
	localparam logic [2:0] ALU_SBC = 3'h3;
	localparam logic [2:0] ALU_AND = 3'h4;
	localparam logic [2:0] ALU_OR = 3'h5;
	localparam logic [2:0] ALU_XOR = 3'h6;

	// One-operand operations, word bits 10..8
	localparam logic [2:0] UN_ADD_ONE = 3'h0;
	localparam logic [2:0] UN_MINUS_ONE = 3'h1;
	localparam logic [2:0] UN_INVERT = 3'h2;
	localparam logic [2:0] UN_ROT_RIGHT = 3'h3;
	localparam logic [2:0] UN_ROT_LEFT = 3'h4;
	localparam logic [2:0] UN_ROT_RIGHT_C = 3'h5;
	localparam logic [2:0] UN_ROT_LEFT_C = 3'h6;

	// Sequencer states
	typedef enum logic [1:0] {
		MIET_RUN,
		MIET_EXTRA,
		MIET_DOWN
	} miet_state_t;

endpackage : miet_pkg

// *** logic/miet_ret_stack.sv ***
// Purpose: Hardware return stack for subroutine calls
// Assumes: Push and pop are one-cycle pulses, never both at once
// Notes: Overflow wraps and overwrites the oldest entry

`timescale 1ns/1ns
`default_nettype none

module miet_ret_stack #(
	parameter int unsigned DEPTH = 6,
	parameter int unsigned W = 12
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [W-1:0] push_data_in,
	output logic [W-1:0] top_out
);

	logic [W-1:0] stk_q [DEPTH];
	logic [2:0] ptr_q;
	logic [2:0] below;

	// Index of the newest entry
	assign below = (ptr_q == 3'h0) ? 3'(DEPTH - 1) : ptr_q - 3'h1;
	assign top_out = stk_q[below];

	// Pointer moves up on push, down on pop, wrapping at depth
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ptr_q <= 3'h0;
		end else if (push_in) begin
			ptr_q <= (ptr_q == 3'(DEPTH - 1)) ? 3'h0 : ptr_q + 3'h1;
		end else if (pop_in) begin
			ptr_q <= below;
		end
	end

	// Entry store
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				stk_q[i] <= '0;
			end
		end else if (push_in) begin
			stk_q[ptr_q] <= push_data_in;
		end
	end

endmodule : miet_ret_stack

`default_nettype wire

// *** logic/miet_data_ram.sv ***
// Purpose: Data memory with registered read port
// Assumes: Write and read addresses share one port address
// Notes: Read data appears one clock after the address

`timescale 1ns/1ns
`default_nettype none

module miet_data_ram #(
	parameter int unsigned DEPTH = 128,
	parameter int unsigned AW = 7
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out
);

	logic [7:0] mem_q [DEPTH];

	// Write port
	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_q[addr_in] <= wr_data_in;
		end
	end

	// Registered read port
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else begin
			rd_data_out <= mem_q[addr_in];
		end
	end

endmodule : miet_data_ram

`default_nettype wire

// *** dv/miet_core_checker.sv ***
// Purpose: Port timing checks of the sequencing core
// Assumes: Effects land on the edge that opens an instruction cycle, table read bytes two clocks later
// Notes: Bound to every core instance
`timescale 1ns/1ns
`default_nettype none
module miet_core_checker
	import miet_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [15:0] prog_data_in,
	input wire logic wake_in,
	input wire logic [11:0] prog_addr_out,
	input wire logic [7:0] acc_out,
	input wire logic [3:0] flags_out,
	input wire logic [7:0] table_high_out,
	input wire logic cycle_start_out,
	input wire logic power_down_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	// Three quiet clocks, then the next start
	sequence s_quiet3;
		!cycle_start_out [*3];
	endsequence
	sequence s_next_start;
		s_quiet3 ##1 cycle_start_out;
	endsequence
	AST_CYCLE_PERIOD: assert property (disable iff (rst_in || power_down_out)
		cycle_start_out |=> s_next_start) else $error("cycle start spacing wrong");
	AST_ADDR_HOLD: assert property (!$stable(prog_addr_out) |-> $rose(cycle_start_out))
		else $error("program address moved inside a cycle");
	AST_ACC_MOMENT: assert property (!$stable(acc_out) |->
		$rose(cycle_start_out) || $past(cycle_start_out, 2)) else $error("acc moved off cycle");
	AST_FLAG_MOMENT: assert property (!$stable(flags_out) |-> $rose(cycle_start_out))
		else $error("flags moved inside a cycle");
	AST_TABLE_MOMENT: assert property (!$stable(table_high_out) |-> $past(cycle_start_out, 2))
		else $error("table byte moved off its load edge");
	AST_DOWN_FROZEN: assert property (power_down_out && !wake_in |=>
		$stable(prog_addr_out) && $stable(acc_out)) else $error("core ran while powered down");
	AST_DOWN_STAY: assert property (power_down_out && !wake_in |=> power_down_out)
		else $error("power down left without wake");
	AST_WAKE_CAUSE: assert property ($fell(power_down_out) |-> $past(wake_in))
		else $error("power down exit without wake");
endmodule : miet_core_checker
bind miet_core miet_core_checker miet_core_checker_i (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .prog_data_in(prog_data_in),
	.wake_in(wake_in), .prog_addr_out(prog_addr_out), .acc_out(acc_out),
	.flags_out(flags_out), .table_high_out(table_high_out),
	.cycle_start_out(cycle_start_out), .power_down_out(power_down_out)
);
`default_nettype wire

// *** dv/test_miet_core.sv ***
// Purpose: Self-checking bench of the sequencing core
// Assumes: Bench plays program memory, answering one nanosecond after each clock edge
// Notes: Expected words hold {c,z} in bits 9..8 above the accumulator
`timescale 1ns/1ns
`default_nettype none
module test_miet_core
	import miet_pkg::*;
;
	logic sys_clk_in = 1'h0;
	logic rst_in = 1'h1;
	logic wake_in = 1'h0;
	logic [15:0] prog_data_in = 16'h0000;
	logic [11:0] prog_addr_out;
	logic [7:0] acc_out;
	logic [3:0] flags_out;
	logic [7:0] table_high_out;
	logic cycle_start_out;
	logic power_down_out;
	logic [15:0] rom [0:4095];
	logic [15:0] prog_q [$];
	logic [11:0] exp_q [$];
	int error_cnt = 0;
	int total_checks = 0;
	int cyc_cnt = 0;
	////////////////////////////////////////
	miet_core miet_core_i (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .prog_data_in(prog_data_in),
		.wake_in(wake_in), .prog_addr_out(prog_addr_out), .acc_out(acc_out),
		.flags_out(flags_out), .table_high_out(table_high_out),
		.cycle_start_out(cycle_start_out), .power_down_out(power_down_out)
	);
	// Clock, program memory and hang guard
	initial begin
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		#1 prog_data_in <= rom[prog_addr_out];
	end
	always @(posedge sys_clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			error_cnt = error_cnt + 1;
			report_and_stop();
		end
	end
	////////////////////////////////////////
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk_v(input string name, input logic [11:0] exp, input logic [11:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_v
	task automatic load();
		for (int i = 0; i < 4096; i++) begin
			rom[i] = (i < prog_q.size()) ? prog_q[i] : 16'h0000;
		end
	endtask : load
	task automatic do_reset();
		@(posedge sys_clk_in);
		#1 rst_in = 1'h1;
		repeat (10) @(posedge sys_clk_in);
		#1 rst_in = 1'h0;
	endtask : do_reset
	// Waits for the next cycle start, just after its edge
	task automatic step();
		do begin
			@(posedge sys_clk_in);
			#1;
		end while (cycle_start_out !== 1'h1);
	endtask : step
	// Runs from reset, checking acc and carry/zero at every cycle start
	task automatic run_seq();
		do_reset();
		foreach (exp_q[k]) begin
			step();
			chk_v("acc_flags", exp_q[k], {2'h0, flags_out[1:0], acc_out});
		end
	endtask : run_seq
	////////////////////////////////////////
	task automatic t_arith();
		prog_q = '{16'h3FFF, 16'h4001, 16'h4201, 16'h4400, 16'h4000};
		exp_q = '{12'h0FF, 12'h300, 12'h2FF, 12'h300, 12'h100};
		load();
		run_seq();
	endtask : t_arith
	// Overflow and half-carry flags after an add and a subtract
	task automatic t_flags();
		prog_q = '{16'h3080, 16'h4080};
		exp_q = '{12'h080, 12'h300};
		load();
		run_seq();
		chk_v("ov_ac_c_z", 12'h00B, {8'h00, flags_out});
		prog_q = '{16'h3000, 16'h4201};
		exp_q = '{12'h000, 12'h2FF};
		load();
		run_seq();
		chk_v("ov_ac_c_z", 12'h006, {8'h00, flags_out});
	endtask : t_flags
	task automatic t_mem();
		prog_q = '{16'h3081, 16'hA020, 16'h7520, 16'h7620, 16'hC720, 16'hB220,
			16'h9020, 16'h8120, 16'h7120, 16'h7420};
		exp_q = '{12'h081, 12'h081, 12'h240, 12'h203, 12'h203, 12'h203,
			12'h205, 12'h205, 12'h203, 12'h208};
		load();
		run_seq();
	endtask : t_mem
	task automatic t_flow();
		prog_q = '{16'h3011, 16'h1010, 16'h3099};
		exp_q = '{12'h011, 12'h011, 12'h011, 12'h011, 12'h011, 12'h022, 12'h022,
			12'h022, 12'h044, 12'h044, 12'h044, 12'h044, 12'h044, 12'h055};
		load();
		rom[16'h10] = 16'h2020;
		rom[16'h11] = 16'h3044;
		rom[16'h12] = 16'h2030;
		rom[16'h13] = 16'h3055;
		rom[16'h20] = 16'h3022;
		rom[16'h21] = 16'h0200;
		rom[16'h30] = 16'h0300;
		run_seq();
	endtask : t_flow
	task automatic t_skip();
		prog_q = '{16'h3040, 16'hA020, 16'hD020, 16'hEE20, 16'h3077, 16'hF020,
			16'h300A, 16'hA006, 16'h3088, 16'h0000, 16'h3033};
		exp_q = '{12'h040, 12'h040, 12'h040, 12'h040, 12'h040, 12'h040,
			12'h0C3, 12'h00A, 12'h00A, 12'h00A, 12'h033};
		load();
		rom[16'h40] = 16'hA5C3;
		run_seq();
		chk_v("table_high", 12'h0A5, {4'h0, table_high_out});
	endtask : t_skip
	task automatic t_halt();
		prog_q = '{16'h0100, 16'h3066};
		load();
		do_reset();
		repeat (6) @(posedge sys_clk_in);
		#1;
		chk_v("power_down", 12'h001, {11'h000, power_down_out});
		repeat (20) @(posedge sys_clk_in);
		#1;
		chk_v("down_acc", 12'h000, {4'h0, acc_out});
		wake_in = 1'h1;
		for (int i = 0; i < 8 && power_down_out === 1'h1; i++) begin
			@(posedge sys_clk_in);
			#1;
		end
		wake_in = 1'h0;
		chk_v("woken", 12'h000, {11'h000, power_down_out});
		step();
		step();
		chk_v("acc_flags", 12'h066, {2'h0, flags_out[1:0], acc_out});
	endtask : t_halt
	initial begin
		t_arith();
		t_flags();
		t_mem();
		t_flow();
		t_skip();
		t_halt();
		report_and_stop();
	end
endmodule : test_miet_core
`default_nettype wire
